// *** pkg/cfg_i2c_pkg.sv ***
`default_nettype none
package cfg_i2c_pkg;
    // Core clock
    localparam int CORE_PERIOD_NS = 50;
    // Target address and framing
    localparam logic [3:0] ADDR_FIXED    = 4'hd;
    localparam int         IMG_BITS      = 96;
    localparam int         WR_BYTES      = 14;
    localparam int         NV_CMD_BYTES  = 2;
    localparam int         RD_LAST_IDX   = 14;
    localparam int         WR_LAST_IDX   = 13;
    localparam int         NV_LAST_IDX   = 1;
    localparam logic [1:0] CMD_WRITE     = 2'h0;
    localparam logic [1:0] CMD_STORE     = 2'h1;
    localparam logic [1:0] CMD_LOAD      = 2'h2;
    localparam logic [7:0] RESERVED_BYTE = 8'h00;
    localparam logic [7:0] IDLE_BYTE     = 8'hff;
    // Three-level strap pin encoding
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_MID  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    // Serial clock rates, quarter periods rounded up
    localparam int STD_KHZ  = 100;
    localparam int FAST_KHZ = 400;
    localparam int QTR_STD  =
        (1000000 / (4 * STD_KHZ) + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int QTR_FAST =
        (1000000 / (4 * FAST_KHZ) + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int STOP_PHASES = 8;
    // Non-volatile timing
    localparam int RESTORE_US     = 3000;
    localparam int RESTORE_CYCLES = RESTORE_US * 1000 / CORE_PERIOD_NS;
    localparam int STORE_US       = 1000;
    localparam int STORE_CYCLES   = STORE_US * 1000 / CORE_PERIOD_NS;
    localparam int BUSY_W         = 24;
    // Controller requests
    typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_STORE, OP_LOAD} host_op_t;
endpackage
`default_nettype wire

// *** pkg/cfg_i2c_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cfg_i2c_if;
    logic c_scl_o;
    logic c_scl_oe;
    logic c_sda_o;
    logic c_sda_oe;
    logic t_sda_o;
    logic t_sda_oe;
    logic scl;
    logic sda;
    // Open-drain wires with pull-ups
    assign scl = !(c_scl_oe && !c_scl_o);
    assign sda = !((c_sda_oe && !c_sda_o) || (t_sda_oe && !t_sda_o));
    modport controller (
        input  scl, sda,
        output c_scl_o, c_scl_oe, c_sda_o, c_sda_oe
    );
    modport target (
        input  scl, sda,
        output t_sda_o, t_sda_oe
    );
endinterface
`default_nettype wire

// *** hw/cfg_i2c_target.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfg_i2c_target #(
    parameter logic [7:0] ID_BYTE        = 8'h5a, // Arbitrary value
    parameter int          RESTORE_CYCLES = cfg_i2c_pkg::RESTORE_CYCLES,
    parameter int          STORE_CYCLES   = cfg_i2c_pkg::STORE_CYCLES,
    parameter logic [cfg_i2c_pkg::IMG_BITS-1:0] NV_INIT = '0
) (
    // Clock, reset, enable
    input  wire logic                           core_clk_i,
    input  wire logic                           resetn_i,
    input  wire logic                           clk_en_i,
    // Serial link
    cfg_i2c_if.target                           bus,
    // Address straps
    input  wire logic [1:0]                     target_addr_select_low_i,
    input  wire logic [1:0]                     target_addr_select_high_i,
    // Programming image and status
    output logic      [cfg_i2c_pkg::IMG_BITS-1:0] config_image_o,
    output logic                                nv_busy_o
);
    import cfg_i2c_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK
    } tgt_state_t;

    logic [5:0]          meta_r;
    logic [5:0]          sync_r;
    logic                scl_q_r;
    logic                sda_q_r;
    tgt_state_t          st_r;
    logic [3:0]          bit_cnt_r;
    logic [3:0]          byte_cnt_r;
    logic [7:0]          sh_r;
    logic [7:0]          tx_r;
    logic                rw_r;
    logic [1:0]          cmd_r;
    logic                sda_oe_r;
    logic [IMG_BITS-1:0] rx_img_r;
    logic [IMG_BITS-1:0] cfg_r;
    logic [IMG_BITS-1:0] nv_r;
    logic                busy_r;
    logic                store_op_r;
    logic [BUSY_W-1:0]   busy_cnt_r;
    logic                scl;
    logic                sda;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_c;
    logic                stop_c;
    logic [3:0]          lvl_idx;
    logic [2:0]          addr_low;
    logic                wr_commit;
    logic                nv_go;
    logic [7:0]          next_tx;

    function automatic logic [7:0] tx_byte(input logic [3:0] idx,
                                           input logic [IMG_BITS-1:0] img);
        int k;
        k = int'(idx);
        if (k == 0)
            tx_byte = ID_BYTE;
        else if (k == 1)
            tx_byte = RESERVED_BYTE;
        else if (k <= WR_LAST_IDX)
            tx_byte = img[8*(WR_LAST_IDX-k) +: 8];
        else
            tx_byte = IDLE_BYTE;
    endfunction

    // Pins and straps pass two flops before use; oversampling keeps up
    // with any serial rate well below the core clock
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            meta_r  <= 6'h03;
            sync_r  <= 6'h03;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else if (clk_en_i) begin
            meta_r  <= {target_addr_select_high_i, target_addr_select_low_i,
                        bus.sda, bus.scl};
            sync_r  <= meta_r;
            scl_q_r <= sync_r[0];
            sda_q_r <= sync_r[1];
        end
    end

    assign scl      = sync_r[0];
    assign sda      = sync_r[1];
    assign scl_rise = scl & ~scl_q_r;
    assign scl_fall = ~scl & scl_q_r;
    assign start_c  = scl & scl_q_r & sda_q_r & ~sda;
    assign stop_c   = scl & scl_q_r & ~sda_q_r & sda;

    // Nine strap combinations; the last one repeats address 6
    always_comb begin
        lvl_idx  = ({2'h0, sync_r[5:4]} << 1) + {2'h0, sync_r[5:4]}
                 + {2'h0, sync_r[3:2]};
        addr_low = (lvl_idx == 4'h8) ? 3'h6 : lvl_idx[2:0];
    end

    assign next_tx   = tx_byte(byte_cnt_r - 4'h1, cfg_r);
    assign wr_commit = stop_c && !rw_r && cmd_r == CMD_WRITE
                       && byte_cnt_r == 4'(WR_BYTES);
    assign nv_go     = stop_c && !rw_r && byte_cnt_r == 4'(NV_CMD_BYTES)
                       && (cmd_r == CMD_STORE || cmd_r == CMD_LOAD);

    // Byte-level protocol engine
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            st_r       <= ST_IDLE;
            bit_cnt_r  <= 4'h0;
            byte_cnt_r <= 4'h0;
            sh_r       <= 8'h00;
            tx_r       <= 8'h00;
            rw_r       <= 1'b0;
            cmd_r      <= CMD_WRITE;
            sda_oe_r   <= 1'b0;
            rx_img_r   <= '0;
        end else if (clk_en_i) begin
            if (stop_c) begin
                st_r       <= ST_IDLE;
                byte_cnt_r <= 4'h0;
                sda_oe_r   <= 1'b0;
            end else if (start_c) begin
                st_r       <= ST_RECV;
                bit_cnt_r  <= 4'h0;
                byte_cnt_r <= 4'h0;
                rw_r       <= 1'b0;
                sda_oe_r   <= 1'b0;
            end else begin
                case (st_r)
                    ST_RECV: begin
                        if (scl_rise) begin
                            sh_r      <= {sh_r[6:0], sda};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == 4'h8) begin
                            if (byte_cnt_r == 4'h0) begin
                                if (sh_r[7:1] == {ADDR_FIXED, addr_low}
                                    && !busy_r) begin
                                    rw_r       <= sh_r[0];
                                    byte_cnt_r <= 4'h1;
                                    sda_oe_r   <= 1'b1;
                                    st_r       <= ST_ACK;
                                end else begin
                                    st_r <= ST_IDLE;
                                end
                            end else if (byte_cnt_r < 4'(WR_BYTES)) begin
                                if (byte_cnt_r == 4'h1)
                                    cmd_r <= sh_r[1:0];
                                else
                                    rx_img_r[8*(WR_LAST_IDX-int'(byte_cnt_r))
                                             +: 8] <= sh_r;
                                byte_cnt_r <= byte_cnt_r + 4'h1;
                                sda_oe_r   <= 1'b1;
                                st_r       <= ST_ACK;
                            end else begin
                                // Surplus bytes are refused
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_r <= 4'h0;
                            if (rw_r) begin
                                tx_r     <= next_tx;
                                sda_oe_r <= ~next_tx[7];
                                st_r     <= ST_SEND;
                            end else begin
                                sda_oe_r <= 1'b0;
                                st_r     <= ST_RECV;
                            end
                        end
                    end
                    ST_SEND: begin
                        if (scl_fall) begin
                            if (bit_cnt_r == 4'h7) begin
                                sda_oe_r  <= 1'b0;
                                bit_cnt_r <= 4'h0;
                                st_r      <= ST_MACK;
                            end else begin
                                tx_r      <= {tx_r[6:0], 1'b0};
                                sda_oe_r  <= ~tx_r[6];
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            if (sda)
                                st_r <= ST_IDLE;
                            else if (byte_cnt_r != 4'hf)
                                byte_cnt_r <= byte_cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            tx_r     <= next_tx;
                            sda_oe_r <= ~next_tx[7];
                            st_r     <= ST_SEND;
                        end
                    end
                    default: begin
                        sda_oe_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Programming registers and non-volatile copy; a new command is
    // only taken once the previous store or load has finished
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cfg_r      <= '0;
            nv_r       <= NV_INIT;
            busy_r     <= 1'b1;
            store_op_r <= 1'b0;
            busy_cnt_r <= BUSY_W'(RESTORE_CYCLES - 1);
        end else if (clk_en_i) begin
            if (busy_r) begin
                if (busy_cnt_r == '0) begin
                    busy_r <= 1'b0;
                    if (store_op_r)
                        nv_r <= cfg_r;
                    else
                        cfg_r <= nv_r;
                end else begin
                    busy_cnt_r <= busy_cnt_r - BUSY_W'(1);
                end
            end else if (wr_commit) begin
                cfg_r <= rx_img_r;
            end else if (nv_go) begin
                busy_r     <= 1'b1;
                store_op_r <= (cmd_r == CMD_STORE);
                busy_cnt_r <= (cmd_r == CMD_STORE)
                            ? BUSY_W'(STORE_CYCLES - 1)
                            : BUSY_W'(RESTORE_CYCLES - 1);
            end
        end
    end

    assign bus.t_sda_o    = 1'b0;
    assign bus.t_sda_oe   = sda_oe_r;
    assign config_image_o = cfg_r;
    assign nv_busy_o      = busy_r;
endmodule
`default_nettype wire

// *** hw/cfg_i2c_controller.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfg_i2c_controller #(
    parameter bit FAST_MODE = 1'b0
) (
    // Clock, reset, enable
    input  wire logic                             core_clk_i,
    input  wire logic                             resetn_i,
    input  wire logic                             clk_en_i,
    // Serial link
    cfg_i2c_if.controller                         bus,
    // Request
    input  wire logic                             req_valid_i,
    input  wire cfg_i2c_pkg::host_op_t            req_op_i,
    input  wire logic [2:0]                       req_addr_low_i,
    input  wire logic [cfg_i2c_pkg::IMG_BITS-1:0] req_wdata_i,
    output logic                                  req_ready_o,
    // Answer
    output logic                                  done_o,
    output logic                                  nack_o,
    output logic      [7:0]                       id_o,
    output logic      [cfg_i2c_pkg::IMG_BITS-1:0] rdata_o
);
    import cfg_i2c_pkg::*;

    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP} hst_t;

    localparam int QTR = FAST_MODE ? QTR_FAST : QTR_STD;

    hst_t                st_r;
    logic [7:0]          qcnt_r;
    logic [2:0]          ph_r;
    logic [3:0]          bi_r;
    logic [3:0]          idx_r;
    host_op_t            op_r;
    logic [2:0]          addr_r;
    logic [IMG_BITS-1:0] wd_r;
    logic [IMG_BITS-1:0] rd_r;
    logic [7:0]          id_r;
    logic [7:0]          rx_r;
    logic                nack_r;
    logic                done_r;
    logic                ready_r;
    logic                scl_oe_r;
    logic                sda_oe_r;
    logic [1:0]          sda_meta_r;
    logic                tick;
    logic                reading;
    logic [3:0]          last_idx;
    logic [7:0]          tx_byte;
    logic                bit_out;

    always_comb begin
        case (op_r)
            OP_READ:  last_idx = 4'(RD_LAST_IDX);
            OP_WRITE: last_idx = 4'(WR_LAST_IDX);
            default:  last_idx = 4'(NV_LAST_IDX);
        endcase
        if (idx_r == 4'h0)
            tx_byte = {ADDR_FIXED, addr_r, op_r == OP_READ};
        else if (idx_r == 4'h1)
            tx_byte = {6'h00, (op_r == OP_STORE) ? CMD_STORE
                            : (op_r == OP_LOAD) ? CMD_LOAD
                            : CMD_WRITE};
        else
            tx_byte = wd_r[8*(WR_LAST_IDX-int'(idx_r)) +: 8];
        reading = (op_r == OP_READ) && idx_r != 4'h0;
        if (bi_r < 4'h8)
            bit_out = reading | tx_byte[3'(7 - int'(bi_r))];
        else
            bit_out = ~reading;
    end

    assign tick = (qcnt_r == 8'h00);

    // The data line comes back from the wire, so it is synchronised
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i)
            sda_meta_r <= 2'h3;
        else if (clk_en_i)
            sda_meta_r <= {sda_meta_r[0], bus.sda};
    end

    // Quarter-period timebase; no clock stretching is honoured
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i)
            qcnt_r <= 8'(QTR - 1);
        else if (clk_en_i) begin
            if (st_r == HS_IDLE || tick)
                qcnt_r <= 8'(QTR - 1);
            else
                qcnt_r <= qcnt_r - 8'h01;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            st_r     <= HS_IDLE;
            ph_r     <= 3'h0;
            bi_r     <= 4'h0;
            idx_r    <= 4'h0;
            op_r     <= OP_WRITE;
            addr_r   <= 3'h0;
            wd_r     <= '0;
            rd_r     <= '0;
            id_r     <= 8'h00;
            rx_r     <= 8'h00;
            nack_r   <= 1'b0;
            done_r   <= 1'b0;
            ready_r  <= 1'b1;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (clk_en_i) begin
            done_r <= 1'b0;
            case (st_r)
                HS_IDLE: begin
                    if (req_valid_i && ready_r) begin
                        op_r    <= req_op_i;
                        addr_r  <= req_addr_low_i;
                        wd_r    <= req_wdata_i;
                        nack_r  <= 1'b0;
                        ready_r <= 1'b0;
                        ph_r    <= 3'h0;
                        st_r    <= HS_START;
                    end
                end
                HS_START: begin
                    if (tick) begin
                        if (ph_r == 3'h0) begin
                            sda_oe_r <= 1'b1;
                            ph_r     <= 3'h1;
                        end else begin
                            scl_oe_r <= 1'b1;
                            ph_r     <= 3'h0;
                            bi_r     <= 4'h0;
                            idx_r    <= 4'h0;
                            st_r     <= HS_BYTE;
                        end
                    end
                end
                HS_BYTE: begin
                    if (tick) begin
                        ph_r <= 3'(ph_r + 3'h1) & 3'h3;
                        case (ph_r)
                            3'h0: sda_oe_r <= ~bit_out;
                            3'h1: scl_oe_r <= 1'b0;
                            3'h2: begin
                                if (bi_r < 4'h8)
                                    rx_r <= {rx_r[6:0], sda_meta_r[1]};
                                else if (!reading && sda_meta_r[1])
                                    nack_r <= 1'b1;
                            end
                            default: begin
                                scl_oe_r <= 1'b1;
                                if (bi_r == 4'h8) begin
                                    bi_r <= 4'h0;
                                    if (reading && idx_r == 4'h1)
                                        id_r <= rx_r;
                                    else if (reading && idx_r > 4'h2)
                                        rd_r[8*(RD_LAST_IDX-int'(idx_r))
                                             +: 8] <= rx_r;
                                    if (nack_r || idx_r == last_idx)
                                        st_r <= HS_STOP;
                                    else
                                        idx_r <= idx_r + 4'h1;
                                end else begin
                                    bi_r <= bi_r + 4'h1;
                                end
                            end
                        endcase
                    end
                end
                HS_STOP: begin
                    if (tick) begin
                        ph_r <= ph_r + 3'h1;
                        if (ph_r == 3'h0)
                            sda_oe_r <= 1'b1;
                        else if (ph_r == 3'h1)
                            scl_oe_r <= 1'b0;
                        else if (ph_r == 3'h2)
                            sda_oe_r <= 1'b0;
                        else if (ph_r == 3'(STOP_PHASES - 1)) begin
                            done_r  <= 1'b1;
                            ready_r <= 1'b1;
                            st_r    <= HS_IDLE;
                        end
                    end
                end
                default: st_r <= HS_IDLE;
            endcase
        end
    end

    assign bus.c_scl_o  = 1'b0;
    assign bus.c_sda_o  = 1'b0;
    assign bus.c_scl_oe = scl_oe_r;
    assign bus.c_sda_oe = sda_oe_r;
    assign req_ready_o  = ready_r;
    assign done_o       = done_r;
    assign nack_o       = nack_r;
    assign id_o         = id_r;
    assign rdata_o      = rd_r;
endmodule
`default_nettype wire

// *** testbench/cfg_i2c_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module cfg_i2c_checker #(
    parameter logic [7:0] ID_BYTE = 8'h5a // Arbitrary value
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Link signals
    input wire logic scl,
    input wire logic sda,
    input wire logic c_sda_oe,
    input wire logic t_sda_oe
);
    import cfg_i2c_pkg::*;
    logic       scl_r, sda_r, rd_r;
    logic [3:0] bit_r;
    logic [3:0] fall_r;
    logic [4:0] byte_r;
    wire        start = scl && scl_r && sda_r && !sda;
    wire        stop  = scl && scl_r && !sda_r && sda;
    wire        rise  = scl && !scl_r;
    wire        fall  = !scl && scl_r;
    always_ff @(posedge core_clk_i) begin
        scl_r <= scl;
        sda_r <= sda;
    end
    // Bit and byte position inside the current frame
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || start) bit_r <= 4'h0;
        else if (rise) bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
    end
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || start) byte_r <= 5'h00;
        else if (rise && bit_r == 4'h8 && byte_r != 5'h1f) byte_r <= byte_r + 5'h01;
    end
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || start) rd_r <= 1'b0;
        else if (rise && bit_r == 4'h7 && byte_r == 5'h00) rd_r <= sda;
    end
    // Count held from the last scl fall; the STOP rise has no fall after
    // it, so the STOP and the next START still see a byte boundary
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i || start) fall_r <= 4'h0;
        else if (fall) fall_r <= bit_r;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    chk_tgt_sda_steady: assert property (
        $changed(t_sda_oe) |-> !scl) else $error("target moved sda, scl high");
    chk_ctl_frame_edge: assert property (
        scl && $changed(c_sda_oe) |-> fall_r == 4'h0)
        else $error("sda edge mid byte");
    chk_ack_slot_only: assert property (
        $rose(t_sda_oe) && (!rd_r || byte_r == 5'h00)
        |-> bit_r == 4'h8 && byte_r <= 5'(WR_LAST_IDX)) else $error("ack out of slot");
    chk_drive_latency: assert property (
        $rose(t_sda_oe) |-> !$past(scl, 2) && $past(scl, 8)) else $error("drive late");
    chk_ack_release: assert property (
        $fell(scl) && t_sda_oe && bit_r == 4'h0 && !rd_r |-> ##[2:5] !t_sda_oe)
        else $error("ack not released");
    chk_id_bits: assert property (
        rd_r && byte_r == 5'h01 && bit_r < 4'h8 && $rose(scl)
        |-> sda == ID_BYTE[3'(4'h7 - bit_r)]) else $error("identity bit wrong");
    chk_reserved_bits: assert property (
        rd_r && byte_r == 5'h02 && bit_r < 4'h8 && $rose(scl)
        |-> sda == RESERVED_BYTE[3'(4'h7 - bit_r)]) else $error("reserved bit wrong");
    chk_quiet_stop: assert property (
        stop |=> !t_sda_oe [*8]) else $error("target drove after stop");
endmodule
`default_nettype wire

// *** testbench/clock_driver_config_serial_slave_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module clock_driver_config_serial_slave_test;
    import cfg_i2c_pkg::*;
    localparam logic [7:0]  ID    = 8'h3c; // Arbitrary value
    localparam logic [95:0] IMG_A = 96'h0123_4567_89ab_cdef_fedc_ba98;
    localparam logic [95:0] IMG_B = 96'hf0e1_d2c3_b4a5_9687_7869_5a4b;
    logic        core_clk, resetn, req_valid, ready, done, nack, busy;
    logic [1:0]  sel_lo, sel_hi;
    host_op_t    req_op;
    logic [2:0]  req_addr;
    logic [95:0] req_wdata, image, rdata;
    logic [7:0]  id;
    int          n_mismatch, checks;
    cfg_i2c_if bus_if();
    always #(CORE_PERIOD_NS / 2) core_clk = ~core_clk;
    // Short restore and store times keep the run brief
    cfg_i2c_target #(.ID_BYTE(ID), .RESTORE_CYCLES(800), .STORE_CYCLES(800))
    i_cfg_i2c_target (.core_clk_i(core_clk), .resetn_i(resetn), .clk_en_i(1'b1),
        .bus(bus_if), .target_addr_select_low_i(sel_lo),
        .target_addr_select_high_i(sel_hi), .config_image_o(image), .nv_busy_o(busy));
    cfg_i2c_controller #(.FAST_MODE(1'b1)) i_cfg_i2c_controller (
        .core_clk_i(core_clk), .resetn_i(resetn), .clk_en_i(1'b1), .bus(bus_if),
        .req_valid_i(req_valid), .req_op_i(req_op), .req_addr_low_i(req_addr),
        .req_wdata_i(req_wdata), .req_ready_o(ready), .done_o(done),
        .nack_o(nack), .id_o(id), .rdata_o(rdata));
    cfg_i2c_checker #(.ID_BYTE(ID)) i_cfg_i2c_checker (.core_clk_i(core_clk),
        .resetn_i(resetn), .scl(bus_if.scl), .sda(bus_if.sda),
        .c_sda_oe(bus_if.c_sda_oe), .t_sda_oe(bus_if.t_sda_oe));
    task automatic close_out();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Every wait is bounded; a hang ends the run
    // Waits for done high, or with on_busy set for busy low
    task automatic wait_for(input bit on_busy);
        int k;
        k = 0;
        while ((on_busy ? busy !== 1'b0 : done !== 1'b1) && k < 20000) begin
            @(posedge core_clk);
            k++;
        end
        if (k == 20000) begin
            n_mismatch++;
            close_out();
        end
    endtask
    task automatic run(input host_op_t op, input logic [2:0] a, input logic [95:0] d);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_op    <= op;
        req_addr  <= a;
        req_wdata <= d;
        @(posedge core_clk);
        req_valid <= 1'b0;
        @(posedge core_clk);
        chk("ready", 96'h0, 96'(ready));
        wait_for(1'b0);
        chk("ready", 96'h1, 96'(ready));
    endtask
    initial begin
        core_clk  = 1'b0;
        resetn    = 1'b0;
        req_valid = 1'b0;
        req_op    = OP_WRITE;
        req_addr  = 3'h0;
        req_wdata = 96'h0;
        sel_lo    = LVL_LOW;
        sel_hi    = LVL_LOW;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        chk("image", 96'h0, image);
        chk("busy", 96'h1, 96'(busy));
        run(OP_READ, 3'h0, 96'h0);
        chk("nack", 96'h1, 96'(nack));
        wait_for(1'b1);
        run(OP_WRITE, 3'h0, IMG_A);
        chk("nack", 96'h0, 96'(nack));
        chk("image", IMG_A, image);
        run(OP_READ, 3'h0, 96'h0);
        chk("id", 96'(ID), 96'(id));
        chk("rdata", IMG_A, rdata);
        run(OP_WRITE, 3'h5, IMG_B);
        chk("nack", 96'h1, 96'(nack));
        chk("image", IMG_A, image);
        run(OP_STORE, 3'h0, 96'h0);
        chk("busy", 96'h1, 96'(busy));
        run(OP_READ, 3'h0, 96'h0);
        chk("nack", 96'h1, 96'(nack));
        wait_for(1'b1);
        run(OP_WRITE, 3'h0, IMG_B);
        chk("image", IMG_B, image);
        run(OP_LOAD, 3'h0, 96'h0);
        wait_for(1'b1);
        chk("image", IMG_A, image);
        // Every strap pair; store is the shortest acked transfer
        for (int hi = 0; hi < 3; hi++) begin
            for (int lo = 0; lo < 3; lo++) begin
                sel_hi <= 2'(hi);
                sel_lo <= 2'(lo);
                run(OP_STORE, (hi == 2 && lo == 2) ? 3'h6
                    : 3'(3 * hi + lo), 96'h0);
                chk("nack", 96'h0, 96'(nack));
                wait_for(1'b1);
            end
        end
        close_out();
    end
endmodule
`default_nettype wire
